// ==== design/iopsc_pkg.sv ====
// Package: register map, field layout, reset values and types of the point conditioner
package iopsc_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
  localparam logic [7:0] OFS_INTERVAL = 8'h08;
  localparam logic [7:0] OFS_THRESH = 8'h0c;
  localparam logic [7:0] OFS_HYST = 8'h10;
  localparam logic [7:0] OFS_PULSE = 8'h14;
  localparam logic [7:0] OFS_OUT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_VALUE = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ANALOG_BIT = 1;
  localparam int CTRL_INV_BIT = 2;
  localparam int CTRL_UNITS_LSB = 4;
  localparam int DEB_LOW_LSB = 8;
  // ----------------------------------------
  // Units codes
  // ----------------------------------------
  localparam logic [3:0] U_RAW = 4'h0;
  localparam logic [3:0] U_MA4 = 4'h1;
  localparam logic [3:0] U_MA0 = 4'h2;
  localparam logic [3:0] U_DISC = 4'h3;
  localparam logic [3:0] U_VOLT = 4'h4;
  localparam logic [3:0] U_HC = 4'h6;
  localparam logic [3:0] U_HF = 4'h7;
  localparam logic [3:0] U_LC = 4'h8;
  localparam logic [3:0] U_LF = 4'h9;
  localparam logic [3:0] U_CNT32 = 4'ha;
  localparam logic [3:0] U_CNT16 = 4'hb;
  // ----------------------------------------
  // Reset values and scaling constants
  // ----------------------------------------
  localparam logic [3:0] UNITS_RST = U_DISC;
  localparam logic [7:0] DEB_CNT_RST = 8'h00;
  localparam logic [15:0] INTERVAL_RST = 16'h0000;
  localparam logic [15:0] PULSE_RST = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [15:0] HYST_RST = 16'h0000;
  localparam logic [16:0] MA4_OFFSET = 17'h0_3333;
  localparam logic [19:0] F_OFFSET_X20 = 20'h00280;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic enable;
    logic analog;
    logic invert;
    logic [3:0] units;
    logic [7:0] high_cnt;
    logic [7:0] low_cnt;
    logic [15:0] interval;
    logic [15:0] thresh;
    logic [15:0] hyst;
    logic [15:0] pulse_sec;
  } iopsc_cfg_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_HOLD = 2'b01
  } iopsc_pulse_t;
endpackage : iopsc_pkg

// ==== design/iopsc_top.sv ====
// Module: single I/O point conditioner with APB register access
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Input goes active after N high samples
// - Input goes low after M low samples
// - Both counts zero: sample passes straight
// - Debounce counts are 8-bit, 0 to 255
// - Sample once every configured interval plus one sample ticks
// - Output holds one for set seconds
// - Pulse width zero leaves written level
// - Analog state ON at threshold
// - OFF below threshold minus hysteresis
// - Compare in units of stored value
// - Signed words are 16-bit two's complement
// - Unsigned words span zero to 65535
// - Code 0 passes raw converter word
// - Code 1 maps 4-20 mA to full word
// - Code 2 maps 0-20 mA to full word
// - Code 3 gives plain ON/OFF value
// - Code 4 maps 0-10 V to full word
// - Codes 6, 7 store temperature times 20
// - Codes 8, 9 store temperature times 2
// - Code 10 counts events in 32 bits
// - Code 11 counts events in 16 bits
module iopsc_top
  import iopsc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Time bases
  input wire logic i_sample_tick,
  input wire logic i_sec_tick,
  // Field side
  input wire logic i_din,
  input wire logic [15:0] i_adc_data,
  output logic o_sample,
  output logic o_state,
  output logic [15:0] o_value,
  output logic o_dout
);

  // ----------------------------------------
  // Decoding helpers for the write path, units encoding and compare
  // ----------------------------------------
  function automatic logic units_valid(input logic [3:0] u);
    units_valid = (u <= U_CNT16) && (u != 4'h5);
  endfunction : units_valid

  function automatic logic units_signed(input logic [3:0] u);
    units_signed = (u >= U_HC) && (u <= U_LF);
  endfunction : units_signed

  function automatic logic [15:0] sat_s16(input logic signed [23:0] v);
    if (v > 24'sh007fff) begin
      sat_s16 = 16'h7fff;
    end else if (v < -24'sh008000) begin
      sat_s16 = 16'h8000;
    end else begin
      sat_s16 = v[15:0];
    end
  endfunction : sat_s16

  iopsc_cfg_t cfg_q;
  logic acc;
  logic wr_en;
  logic [15:0] ivl_cnt_q;
  logic samp_q;
  logic din_q;
  logic deb_state_q;
  logic [7:0] run_q;
  logic ana_on_q;
  logic [31:0] count_q;
  logic [15:0] value_q;
  logic [15:0] value_d;
  logic out_lvl_q;
  logic [15:0] pulse_cnt_q;
  iopsc_pulse_t pulse_q;
  logic [31:0] rdata_d;
  logic addr_ok;

  assign acc = i_psel && i_penable && !o_pready;
  assign wr_en = acc && i_pwrite;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q.enable <= 1'b0;
      cfg_q.analog <= 1'b0;
      cfg_q.invert <= 1'b0;
      cfg_q.units <= UNITS_RST;
      cfg_q.high_cnt <= DEB_CNT_RST;
      cfg_q.low_cnt <= DEB_CNT_RST;
      cfg_q.interval <= INTERVAL_RST;
      cfg_q.thresh <= THRESH_RST;
      cfg_q.hyst <= HYST_RST;
      cfg_q.pulse_sec <= PULSE_RST;
    end else if (wr_en) begin
      unique case (i_paddr)
        OFS_CTRL: begin
          cfg_q.enable <= i_pwdata[CTRL_EN_BIT];
          cfg_q.analog <= i_pwdata[CTRL_ANALOG_BIT];
          cfg_q.invert <= i_pwdata[CTRL_INV_BIT];
          if (units_valid(i_pwdata[CTRL_UNITS_LSB +: 4])) begin
            cfg_q.units <= i_pwdata[CTRL_UNITS_LSB +: 4];
          end
        end
        OFS_DEBOUNCE: begin
          cfg_q.high_cnt <= i_pwdata[7:0];
          cfg_q.low_cnt <= i_pwdata[DEB_LOW_LSB +: 8];
        end
        OFS_INTERVAL: cfg_q.interval <= i_pwdata[15:0];
        OFS_THRESH: cfg_q.thresh <= i_pwdata[15:0];
        OFS_HYST: cfg_q.hyst <= i_pwdata[15:0];
        OFS_PULSE: cfg_q.pulse_sec <= i_pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sample interval timer
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ivl_cnt_q <= 16'h0000;
      samp_q <= 1'b0;
    end else begin
      samp_q <= 1'b0;
      if (!cfg_q.enable) begin
        ivl_cnt_q <= 16'h0000;
      end else if (i_sample_tick) begin
        if (ivl_cnt_q >= cfg_q.interval) begin
          ivl_cnt_q <= 16'h0000;
          samp_q <= 1'b1;
        end else begin
          ivl_cnt_q <= ivl_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Discrete debounce
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      din_q <= 1'b0;
      deb_state_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      din_q <= i_din ^ cfg_q.invert;
      if (samp_q && !cfg_q.analog) begin
        if (cfg_q.high_cnt == 8'h00 && cfg_q.low_cnt == 8'h00) begin
          deb_state_q <= din_q;
          run_q <= 8'h00;
        end else if (din_q == deb_state_q) begin
          run_q <= 8'h00;
        end else if (din_q && (run_q + 8'h01 >= cfg_q.high_cnt)) begin
          deb_state_q <= 1'b1;
          run_q <= 8'h00;
        end else if (!din_q && (run_q + 8'h01 >= cfg_q.low_cnt)) begin
          deb_state_q <= 1'b0;
          run_q <= 8'h00;
        end else begin
          run_q <= run_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Event counter, counts rising edges while enabled in units codes 10 and 11
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= 32'h0000_0000;
    end else if (wr_en && i_paddr == OFS_COUNT) begin
      count_q <= i_pwdata;
    end else if (cfg_q.enable && (i_din ^ cfg_q.invert) && !din_q) begin
      if (cfg_q.units == U_CNT16) begin
        count_q <= {16'h0000, count_q[15:0] + 16'h0001};
      end else if (cfg_q.units == U_CNT32) begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Units encoding of the converter word
  // ----------------------------------------
  logic [16:0] ma_diff;
  logic [18:0] ma_scaled;
  logic signed [23:0] tf_x20;
  logic signed [23:0] tc_x20;

  always_comb begin
    tc_x20 = 24'(signed'(i_adc_data));
    tf_x20 = 24'((tc_x20 * 24'sd9) / 24'sd5) + signed'({4'h0, F_OFFSET_X20});
    ma_diff = {1'b0, i_adc_data} - MA4_OFFSET;
    ma_scaled = 19'(({2'b00, ma_diff} * 19'd5) >> 2);
    value_d = value_q;
    unique case (cfg_q.units)
      U_RAW: value_d = i_adc_data;
      U_MA4: begin
        if (ma_diff[16]) begin
          value_d = 16'h0000;
        end else if (ma_scaled > 19'h0_ffff) begin
          value_d = 16'hffff;
        end else begin
          value_d = ma_scaled[15:0];
        end
      end
      U_MA0: value_d = i_adc_data;
      U_VOLT: value_d = i_adc_data;
      U_DISC: value_d = {15'h0000, deb_state_q};
      U_HC: value_d = sat_s16(tc_x20);
      U_HF: value_d = sat_s16(tf_x20);
      U_LC: value_d = sat_s16(tc_x20 / 24'sd10);
      U_LF: value_d = sat_s16(tf_x20 / 24'sd10);
      U_CNT32: value_d = count_q[15:0];
      U_CNT16: value_d = count_q[15:0];
      default: value_d = value_q;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      value_q <= 16'h0000;
    // Counter and ON/OFF words track their source every cycle
    end else if (cfg_q.units == U_CNT32 || cfg_q.units == U_CNT16 || cfg_q.units == U_DISC) begin
      value_q <= value_d;
    end else if (samp_q) begin
      value_q <= value_d;
    end
  end

  // ----------------------------------------
  // Threshold and hysteresis on stored value
  // ----------------------------------------
  logic signed [17:0] val_x;
  logic signed [17:0] thr_x;
  logic signed [17:0] off_x;

  // Judge the word being stored now, not the previous sample
  always_comb begin
    if (units_signed(cfg_q.units)) begin
      val_x = 18'(signed'(value_d));
      thr_x = 18'(signed'(cfg_q.thresh));
    end else begin
      val_x = signed'({2'b00, value_d});
      thr_x = signed'({2'b00, cfg_q.thresh});
    end
    off_x = thr_x - signed'({2'b00, cfg_q.hyst});
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ana_on_q <= 1'b0;
    end else if (samp_q && cfg_q.analog) begin
      if (val_x >= thr_x) begin
        ana_on_q <= 1'b1;
      end else if (val_x < off_x) begin
        ana_on_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Discrete output with pulse stretch
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_lvl_q <= 1'b0;
      pulse_cnt_q <= 16'h0000;
      pulse_q <= PULSE_IDLE;
    end else if (wr_en && i_paddr == OFS_OUT) begin
      out_lvl_q <= i_pwdata[0];
      pulse_cnt_q <= cfg_q.pulse_sec;
      if (i_pwdata[0] && cfg_q.pulse_sec != 16'h0000) begin
        pulse_q <= PULSE_HOLD;
      end else begin
        pulse_q <= PULSE_IDLE;
      end
    end else begin
      unique case (pulse_q)
        PULSE_IDLE: begin
        end
        PULSE_HOLD: begin
          if (i_sec_tick) begin
            if (pulse_cnt_q <= 16'h0001) begin
              out_lvl_q <= 1'b0;
              pulse_cnt_q <= 16'h0000;
              pulse_q <= PULSE_IDLE;
            end else begin
              pulse_cnt_q <= pulse_cnt_q - 16'h0001;
            end
          end
        end
        default: pulse_q <= PULSE_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sample <= 1'b0;
      o_state <= 1'b0;
      o_value <= 16'h0000;
      o_dout <= 1'b0;
    end else begin
      o_sample <= samp_q;
      o_state <= cfg_q.analog ? ana_on_q : deb_state_q;
      o_value <= value_q;
      o_dout <= out_lvl_q ^ cfg_q.invert;
    end
  end

  // ----------------------------------------
  // APB read path, one wait state
  // ----------------------------------------
  always_comb begin
    rdata_d = RD_ZERO;
    addr_ok = 1'b1;
    unique case (i_paddr)
      OFS_CTRL: begin
        rdata_d[CTRL_EN_BIT] = cfg_q.enable;
        rdata_d[CTRL_ANALOG_BIT] = cfg_q.analog;
        rdata_d[CTRL_INV_BIT] = cfg_q.invert;
        rdata_d[CTRL_UNITS_LSB +: 4] = cfg_q.units;
      end
      OFS_DEBOUNCE: rdata_d[15:0] = {cfg_q.low_cnt, cfg_q.high_cnt};
      OFS_INTERVAL: rdata_d[15:0] = cfg_q.interval;
      OFS_THRESH: rdata_d[15:0] = cfg_q.thresh;
      OFS_HYST: rdata_d[15:0] = cfg_q.hyst;
      OFS_PULSE: rdata_d[15:0] = cfg_q.pulse_sec;
      OFS_OUT: rdata_d[0] = out_lvl_q;
      OFS_STATUS: rdata_d[2:0] = {out_lvl_q, ana_on_q, deb_state_q};
      OFS_VALUE: rdata_d[15:0] = value_q;
      OFS_COUNT: rdata_d = count_q;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= RD_ZERO;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc && !addr_ok;
      if (acc && !i_pwrite) begin
        o_prdata <= rdata_d;
      end
    end
  end

endmodule : iopsc_top

// ==== tb/iopsc_checker_assertions.sv ====
// Checker: port timing relations of the point conditioner
`timescale 1ns/1ps
module iopsc_checker
  import iopsc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Time bases and field side
  input wire logic i_sample_tick,
  input wire logic i_sec_tick,
  input wire logic o_sample,
  input wire logic o_state,
  input wire logic o_dout
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_taken;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  AST_ONE_WAIT: assert property (s_taken |=> s_answer)
    else $error("pready not one cycle after access");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  AST_ERR_READ_ZERO: assert property (o_pslverr && !i_pwrite |-> o_prdata == RD_ZERO)
    else $error("unmapped read not zero");
  AST_MAPPED_OK: assert property (o_pready && i_paddr <= OFS_COUNT && i_paddr[1:0] == 2'h0
    |-> !o_pslverr) else $error("mapped access flagged");
  AST_PRDATA_HOLD: assert property (!(i_psel && i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data moved without read");
  AST_SAMPLE_CAUSE: assert property (
    o_sample |-> $past(i_sample_tick, 2) || $past(i_sample_tick, 3))
    else $error("sample without tick");
  AST_STATE_CAUSE: assert property (
    $changed(o_state) |-> o_sample || $past(o_sample) || $past(o_sample, 2)
    || $past(i_psel, 2) || $past(i_psel, 3)) else $error("state moved without sample");
  AST_DOUT_RISE: assert property (
    $rose(o_dout) |-> $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
    else $error("output rose without write");
  AST_DOUT_FALL: assert property (
    $fell(o_dout) |-> $past(i_sec_tick) || $past(i_sec_tick, 2)
    || $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
    else $error("output fell without tick or write");
endmodule : iopsc_checker

// ==== tb/iopsc_field.sv ====
// Field-side model: discrete contact and converter word
`timescale 1ns/1ps
module iopsc_field (
  // Clock
  input wire logic i_sys_clk,
  // Bench commands
  input wire logic i_lvl,
  input wire logic [15:0] i_word,
  // Field lines
  output logic o_din,
  output logic [15:0] o_adc
);
  // Lines settle one cycle after a command
  always_ff @(posedge i_sys_clk) begin
    o_din <= i_lvl;
    o_adc <= i_word;
  end
endmodule : iopsc_field

// ==== tb/tb_iopsc_top.sv ====
// Testbench: scenario tasks for the point conditioner
`timescale 1ns/1ps
module tb_iopsc_top;
  import iopsc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_sample_tick = 1'b0;
  logic i_sec_tick = 1'b0;
  logic din_lvl = 1'b0;
  logic [15:0] adc_lvl = 16'h0;
  logic i_din, o_pready, o_pslverr, o_sample, o_state, o_dout, err_q;
  logic [15:0] i_adc_data, o_value;
  logic [31:0] o_prdata, rd_q;
  int err_count = 0;
  int check_count = 0;
  int samp_cnt = 0;
  logic [3:0] uc [9] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [15:0] ua [9] = '{16'h1234, 16'h3333, 16'h8000, 16'habcd, 16'h4321, 16'hff9c,
    16'h00c8, 16'h00c8, 16'h00c8};
  logic [15:0] ue [9] = '{16'h1234, 16'h0000, 16'h6000, 16'habcd, 16'h4321, 16'hff9c,
    16'h03e8, 16'h0014, 16'h0064};

  iopsc_field i_iopsc_field (.i_sys_clk(i_sys_clk), .i_lvl(din_lvl), .i_word(adc_lvl),
    .o_din(i_din), .o_adc(i_adc_data));
  iopsc_top i_iopsc_top (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_sample_tick(i_sample_tick), .i_sec_tick(i_sec_tick), .i_din(i_din),
    .i_adc_data(i_adc_data), .o_sample(o_sample), .o_state(o_state), .o_value(o_value),
    .o_dout(o_dout));

  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_sample === 1'b1) samp_cnt++;
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd_q = o_prdata;
    err_q = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb
  task automatic tick(input logic sec, input int n);
    repeat (n) begin
      if (sec) i_sec_tick <= 1'b1;
      else i_sample_tick <= 1'b1;
      @(posedge i_sys_clk);
      i_sec_tick <= 1'b0;
      i_sample_tick <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
    end
  endtask : tick
  task automatic samp(input logic v, input int n);
    din_lvl <= v;
    repeat (3) @(posedge i_sys_clk);
    tick(1'b0, n);
  endtask : samp
  task automatic asamp(input logic [15:0] w, input logic exp);
    adc_lvl <= w;
    samp(1'b0, 1);
    check(32'(o_state), 32'(exp));
  endtask : asamp
  task automatic edges(input int n);
    repeat (n) begin
      din_lvl <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      din_lvl <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
    end
  endtask : edges

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd_q, {24'h0, UNITS_RST, 4'h0});
    apb(1'b0, OFS_DEBOUNCE, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b1, 8'h40, 32'h5a5a_5a5a);
    apb(1'b0, 8'h40, 32'h0);
    check({rd_q[30:0], err_q}, 32'h1);
  endtask : t_regs
  task automatic t_debounce();
    apb(1'b1, OFS_CTRL, 32'h31);
    apb(1'b1, OFS_DEBOUNCE, 32'h0203);
    samp(1'b1, 2);
    check(32'(o_state), 32'h0);
    samp(1'b0, 1);
    samp(1'b1, 2);
    check(32'(o_state), 32'h0);
    samp(1'b1, 1);
    check(32'(o_state), 32'h1);
    samp(1'b0, 1);
    check(32'(o_state), 32'h1);
    samp(1'b0, 1);
    check(32'(o_state), 32'h0);
    apb(1'b1, OFS_DEBOUNCE, 32'h0);
    samp(1'b1, 1);
    check(32'(o_state), 32'h1);
    apb(1'b1, OFS_INTERVAL, 32'h2);
    samp_cnt = 0;
    samp(1'b0, 6);
    check(32'(samp_cnt), 32'h2);
    apb(1'b1, OFS_INTERVAL, 32'h0);
  endtask : t_debounce
  task automatic t_analog();
    apb(1'b1, OFS_CTRL, 32'h03);
    apb(1'b1, OFS_THRESH, 32'h3e8);
    apb(1'b1, OFS_HYST, 32'h64);
    asamp(16'h03e7, 1'b0);
    asamp(16'h03e8, 1'b1);
    asamp(16'h0384, 1'b1);
    asamp(16'h0383, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h63);
    apb(1'b1, OFS_THRESH, 32'hff9c);
    asamp(16'hff9b, 1'b0);
    asamp(16'h0000, 1'b1);
  endtask : t_analog
  task automatic t_units();
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, OFS_CTRL, {24'h0, uc[k], 4'h3});
      adc_lvl <= ua[k];
      samp(1'b0, 1);
      check(32'(o_value), 32'(ue[k]));
    end
    apb(1'b1, OFS_CTRL, 32'h53);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd_q, 32'h93);
    apb(1'b1, OFS_CTRL, 32'hc1);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd_q, 32'h91);
  endtask : t_units
  task automatic t_count();
    apb(1'b1, OFS_CTRL, 32'ha1);
    apb(1'b1, OFS_COUNT, 32'hfffe);
    edges(3);
    apb(1'b0, OFS_COUNT, 32'h0);
    check(rd_q, 32'h0001_0001);
    apb(1'b1, OFS_CTRL, 32'hb1);
    apb(1'b1, OFS_COUNT, 32'hfffe);
    edges(3);
    check(32'(o_value), 32'h1);
  endtask : t_count
  task automatic t_pulse();
    apb(1'b1, OFS_CTRL, 32'h31);
    apb(1'b1, OFS_PULSE, 32'h3);
    apb(1'b1, OFS_OUT, 32'h1);
    tick(1'b1, 2);
    check(32'(o_dout), 32'h1);
    tick(1'b1, 1);
    check(32'(o_dout), 32'h0);
    apb(1'b1, OFS_PULSE, 32'h0);
    apb(1'b1, OFS_OUT, 32'h1);
    tick(1'b1, 4);
    check(32'(o_dout), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h35);
    samp(1'b0, 1);
    check(32'(o_state), 32'h1);
    check(32'(o_value), 32'h1);
    check(32'(o_dout), 32'h0);
  endtask : t_pulse

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_regs();
    t_debounce();
    t_analog();
    t_units();
    t_count();
    t_pulse();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    summarize();
  end
endmodule : tb_iopsc_top

bind iopsc_top iopsc_checker i_iopsc_checker (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_sample_tick(i_sample_tick), .i_sec_tick(i_sec_tick), .o_sample(o_sample),
  .o_state(o_state), .o_dout(o_dout));
